// file: design/ssr_fifo.sv
`timescale 1ns/1ps
module ssr_fifo (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // character store port
  ssr_fifo_if.store fifo
);
  logic [ssr_pkg::CHAR_W-1:0] mem [0:ssr_pkg::FIFO_DEPTH-1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire do_push = fifo.push && !fifo.full;
  wire do_pop = fifo.pop && !fifo.empty;

  assign fifo.head = mem[rd_ptr_reg];
  assign fifo.full = (count_reg == 2'h2);
  assign fifo.empty = (count_reg == 2'h0);

  // cleared so the ninth-bit status reads a defined level before the first character
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < ssr_pkg::FIFO_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (do_push) begin
      mem[wr_ptr_reg] <= fifo.push_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || fifo.flush) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (do_pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, do_push} - {1'b0, do_pop};
    end
  end
endmodule // ssr_fifo

// file: design/ssr_sync.sv
`timescale 1ns/1ps
module ssr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // levels from outside the domain
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // ssr_sync

// file: design/ssr_top.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ssr_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins, clock from the master
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  // core interface
  input wire logic core_sleep,
  output logic irq,
  output logic wake_req,
  output logic vector_req
);
  logic [7:0] rx_status_reg;
  logic [7:0] tx_status_reg;
  logic [7:0] baud_reg;
  logic [7:0] int_ctrl_reg;
  logic [ssr_pkg::EV_BITS-1:0] ev_status_reg;
  logic [ssr_pkg::EV_BITS-1:0] ev_status_next;
  logic [ssr_pkg::EV_BITS-1:0] ev_mask_reg;
  logic overrun_error_flag_reg;
  logic [ssr_pkg::CHAR_W-1:0] receive_shift_register_reg;
  logic [3:0] bit_cnt_reg;
  logic sck_prev_reg;
  ssr_pkg::ssr_rx_state_type state_reg;
  ssr_pkg::ssr_rx_state_type state_next;
  logic [1:0] pins_sync;

  ssr_fifo_if fifo_bus ();

  // pins cross into mclk before anything looks at them
  ssr_sync #(
    .WIDTH(ssr_pkg::SYNC_W)
  ) u_pin_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in({serial_clock_pin, serial_data_pin}),
    .sync_out(pins_sync)
  );

  ssr_fifo u_fifo (
    .mclk(mclk),
    .reset(reset),
    .fifo(fifo_bus.store)
  );

  // configuration decode
  wire sck_s = pins_sync[1];
  wire sdat_s = pins_sync[0];
  wire serial_port_enable = rx_status_reg[ssr_pkg::RS_PORT_EN];
  wire nine_bit_receive_enable = rx_status_reg[ssr_pkg::RS_NINE_BIT];
  wire continuous_receive_enable = rx_status_reg[ssr_pkg::RS_CONT_RX];
  wire sync_mode = tx_status_reg[ssr_pkg::TS_SYNC];
  wire clock_source_select = tx_status_reg[ssr_pkg::TS_CLK_SRC];
  wire clock_polarity = baud_reg[ssr_pkg::BD_SCKP];
  wire global_interrupt_enable = int_ctrl_reg[ssr_pkg::IC_GLOBAL_EN];
  wire peripheral_interrupt_enable = int_ctrl_reg[ssr_pkg::IC_PERIPH_EN];
  wire receive_interrupt_enable = int_ctrl_reg[ssr_pkg::IC_RX_IE];
  // slave mode needs the clock taken from outside
  wire slave_mode = sync_mode && !clock_source_select;
  // single_receive_enable is never consulted here; slave reception is enabled by the port enable and slave mode alone
  wire rx_enable = serial_port_enable && slave_mode;

  // apb decode
  wire setup_hit = psel && penable && !pready;
  wire access_done = psel && penable && pready;
  wire wr_done = access_done && pwrite;
  wire sel_rx_status = (paddr == ssr_pkg::ADDR_RX_STATUS);
  wire sel_tx_status = (paddr == ssr_pkg::ADDR_TX_STATUS);
  wire sel_baud = (paddr == ssr_pkg::ADDR_BAUD);
  wire sel_rx_data = (paddr == ssr_pkg::ADDR_RX_DATA);
  wire sel_ev_status = (paddr == ssr_pkg::ADDR_IRQ_STATUS);
  wire sel_ev_mask = (paddr == ssr_pkg::ADDR_IRQ_MASK);
  wire sel_int_ctrl = (paddr == ssr_pkg::ADDR_INT_CTRL);
  wire addr_mapped = sel_rx_status || sel_tx_status || sel_baud || sel_rx_data
    || sel_ev_status || sel_ev_mask || sel_int_ctrl;
  wire [7:0] wbyte = pwdata[7:0];
  // the pop happens at the data phase capture so prdata and the pop agree
  wire rx_data_pop = setup_hit && !pwrite && sel_rx_data;

  // overrun release by dropping continuous receive or port enable
  wire rs_write = wr_done && sel_rx_status;
  wire overrun_error_flag_release = rs_write && (!wbyte[ssr_pkg::RS_CONT_RX] || !wbyte[ssr_pkg::RS_PORT_EN]);

  // receive shifter
  wire sck_edge = clock_polarity ? (sck_s && !sck_prev_reg) : (!sck_s && sck_prev_reg);
  wire [3:0] last_bit = nine_bit_receive_enable ? ssr_pkg::LAST_BIT_9 : ssr_pkg::LAST_BIT_8;
  wire [ssr_pkg::CHAR_W-1:0] shift_next = {sdat_s, receive_shift_register_reg[ssr_pkg::CHAR_W-1:1]};
  wire char_done = (state_reg == ssr_pkg::RX_SHIFT) && sck_edge && (bit_cnt_reg == last_bit);
  // lsb first: an 8-bit character sits in the top eight bits of the shifter
  wire [ssr_pkg::CHAR_W-1:0] char_word = nine_bit_receive_enable ? shift_next
    : {1'b0, shift_next[ssr_pkg::CHAR_W-1:1]};
  wire char_store = char_done && !fifo_bus.full;
  wire char_overrun = char_done && fifo_bus.full;
  wire receive_complete_flag = !fifo_bus.empty;

  assign fifo_bus.push = char_store;
  assign fifo_bus.push_data = char_word;
  assign fifo_bus.pop = rx_data_pop;
  assign fifo_bus.flush = !serial_port_enable;

  // register read data
  wire [7:0] rx_status_rd = {rx_status_reg[7:3], 1'b0, overrun_error_flag_reg,
    fifo_bus.head[ssr_pkg::CHAR_W-1]};
  wire [7:0] baud_rd = {1'b0, !rx_enable, 1'b0, baud_reg[4:0]};
  wire [7:0] rd_byte = sel_rx_status ? rx_status_rd
    : sel_tx_status ? tx_status_reg
    : sel_baud ? baud_rd
    : sel_rx_data ? fifo_bus.head[7:0]
    : sel_ev_status ? {6'h00, ev_status_reg}
    : sel_ev_mask ? {6'h00, ev_mask_reg}
    : sel_int_ctrl ? int_ctrl_reg
    : 8'h00;

  // sticky events, set beats a same-cycle write-one clear
  wire [ssr_pkg::EV_BITS-1:0] ev_set = {char_overrun, char_store};
  wire [ssr_pkg::EV_BITS-1:0] ev_clr = (wr_done && sel_ev_status) ? wbyte[1:0] : 2'h0;
  assign ev_status_next = (ev_status_reg & ~ev_clr) | ev_set;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ssr_pkg::RX_OFF: begin
        if (rx_enable) begin
          state_next = ssr_pkg::RX_SHIFT;
        end
      end
      ssr_pkg::RX_SHIFT: begin
        if (!rx_enable) begin
          state_next = ssr_pkg::RX_OFF;
        end else if (char_overrun) begin
          state_next = ssr_pkg::RX_HALT;
        end
      end
      ssr_pkg::RX_HALT: begin
        if (!rx_enable) begin
          state_next = ssr_pkg::RX_OFF;
        end else if (overrun_error_flag_release) begin
          state_next = ssr_pkg::RX_SHIFT;
        end
      end
      default: begin
        state_next = ssr_pkg::RX_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ssr_pkg::RX_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // bit counter and shifter; a new frame restarts at bit zero
  always_ff @(posedge mclk) begin
    if (reset || state_reg != ssr_pkg::RX_SHIFT) begin
      bit_cnt_reg <= 4'h0;
      receive_shift_register_reg <= '0;
    end else if (sck_edge) begin
      receive_shift_register_reg <= shift_next;
      bit_cnt_reg <= char_done ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !serial_port_enable) begin
      overrun_error_flag_reg <= 1'b0;
    end else if (char_overrun) begin
      overrun_error_flag_reg <= 1'b1;
    end else if (overrun_error_flag_release) begin
      overrun_error_flag_reg <= 1'b0;
    end
  end

  // control registers; port enable low keeps them and the event bits, and clears only the fifo, overrun flag and receive state
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_status_reg <= ssr_pkg::RS_RESET;
      tx_status_reg <= ssr_pkg::TS_RESET;
      baud_reg <= ssr_pkg::BD_RESET;
      int_ctrl_reg <= ssr_pkg::IC_RESET;
      ev_mask_reg <= ssr_pkg::EV_RESET;
    end else if (wr_done) begin
      if (sel_rx_status) begin
        rx_status_reg <= wbyte & ssr_pkg::RS_WMASK;
      end
      if (sel_tx_status) begin
        tx_status_reg <= wbyte & ssr_pkg::TS_WMASK;
      end
      if (sel_baud) begin
        baud_reg <= wbyte & ssr_pkg::BD_WMASK;
      end
      if (sel_int_ctrl) begin
        int_ctrl_reg <= wbyte & ssr_pkg::IC_WMASK;
      end
      if (sel_ev_mask) begin
        ev_mask_reg <= wbyte[1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_status_reg <= ssr_pkg::EV_RESET;
    end else begin
      ev_status_reg <= ev_status_next;
    end
  end

  // apb answer: one wait state, data captured in the first access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_hit;
      if (setup_hit) begin
        prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
        pslverr <= !addr_mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // core-facing requests
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
      wake_req <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      irq <= |(ev_status_next & ev_mask_reg);
      wake_req <= core_sleep && receive_interrupt_enable && receive_complete_flag;
      vector_req <= global_interrupt_enable && peripheral_interrupt_enable
        && receive_interrupt_enable && receive_complete_flag;
    end
  end
endmodule // ssr_top

// file: inc/ssr_fifo_if.sv
`timescale 1ns/1ps
interface ssr_fifo_if;
  logic push;
  logic [ssr_pkg::CHAR_W-1:0] push_data;
  logic pop;
  logic flush;
  logic [ssr_pkg::CHAR_W-1:0] head;
  logic full;
  logic empty;
  modport producer (output push, output push_data, output pop, output flush,
                    input head, input full, input empty);
  modport store (input push, input push_data, input pop, input flush,
                 output head, output full, output empty);
endinterface

// file: inc/ssr_pkg.sv
package ssr_pkg;
  // byte addresses of the register words
  localparam logic [7:0] ADDR_RX_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h18;
  // receive_status_control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE_BIT = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX = 4;
  localparam int RS_ADDEN = 3;
  localparam int RS_FERR = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH_BIT = 0;
  // transmit_status_control fields
  localparam int TS_CLK_SRC = 7;
  localparam int TS_SYNC = 4;
  // baud_control fields
  localparam int BD_RCIDL = 6;
  localparam int BD_SCKP = 4;
  // interrupt_control fields
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_PERIPH_EN = 6;
  localparam int IC_RX_IE = 5;
  // sticky event bits
  localparam int EV_RX_DONE = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_BITS = 2;
  // writable masks and reset values
  localparam logic [7:0] RS_WMASK = 8'hf8;
  localparam logic [7:0] TS_WMASK = 8'hf0;
  localparam logic [7:0] BD_WMASK = 8'h1b;
  localparam logic [7:0] IC_WMASK = 8'he0;
  localparam logic [7:0] RS_RESET = 8'h00;
  localparam logic [7:0] TS_RESET = 8'h00;
  localparam logic [7:0] BD_RESET = 8'h00;
  localparam logic [7:0] IC_RESET = 8'h00;
  localparam logic [1:0] EV_RESET = 2'h0;
  // character layout
  localparam int CHAR_W = 9;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam int FIFO_DEPTH = 2;
  localparam int SYNC_W = 2;

  typedef enum logic [1:0] {
    RX_OFF = 2'b00,
    RX_SHIFT = 2'b01,
    RX_HALT = 2'b10
  } ssr_rx_state_type;
endpackage

// file: tb/ssr_serial_master.sv
`timescale 1ns/1ps
module ssr_serial_master (
  // serial lines toward the slave
  output logic serial_clock,
  output logic serial_data
);
  // pins are driven as plain digital levels, no analog function
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end
  // clock idles low between frames
  task automatic send(input logic [8:0] ch, input int nbits, input logic pol);
    #7;
    for (int i = 0; i < nbits; i++) begin // lsb first
      if (pol) begin
        // rising-edge sampling: data settles while the clock is low
        serial_data = ch[i];
        #80;
        serial_clock = 1'b1;
        #80;
        serial_clock = 1'b0;
      end else begin
        serial_clock = 1'b1;
        serial_data = ch[i];
        #80;
        serial_clock = 1'b0;
        #80;
      end
    end
    // released line shows no held value
    serial_data = ~serial_data;
  endtask
endmodule // ssr_serial_master

// file: tb/ssr_top_properties.sv
`timescale 1ns/1ps
module ssr_top_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core
  input wire logic core_sleep,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic vector_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire acc = psel && penable && !pready;
  wire bad = paddr > 8'h18;
  a_ready_answer: assert property (acc |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_unmapped: assert property (acc && bad |=> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (acc && !bad && paddr[1:0] == 2'h0 |=> !pslverr) else $error("bad pslverr");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper");
  a_wake_sleep: assert property (!core_sleep |=> !wake_req) else $error("wake awake");
  a_vector_wake: assert property (vector_req && $past(core_sleep) |-> wake_req) else $error("no wake");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && !irq && !wake_req && !vector_req)
    else $error("reset outputs");
endmodule // ssr_top_properties

bind ssr_top ssr_top_properties u_ssr_top_properties (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_sleep(core_sleep), .irq(irq),
  .wake_req(wake_req), .vector_req(vector_req));

// file: tb/sync_slave_serial_receiver_test.sv
`timescale 1ns/1ps
module sync_slave_serial_receiver_test;
  typedef struct packed {
    logic [7:0] rs;
    logic [8:0] ch;
  } ssr_row_type;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic core_sleep = 1'b0;
  logic link_pol = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  wire wake_req;
  wire vector_req;
  wire sclk;
  wire sdat;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
  ssr_row_type rows [4] = '{'{8'h90, 9'h0a5}, '{8'h80, 9'h03c}, '{8'hf0, 9'h1c3}, '{8'he0, 9'h05a}};

  ssr_top u_ssr_top (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_pin(sclk),
    .serial_data_pin(sdat), .core_sleep(core_sleep), .irq(irq), .wake_req(wake_req), .vector_req(vector_req));
  ssr_serial_master u_ssr_serial_master (.serial_clock(sclk), .serial_data(sdat));

  always #10 mclk = ~mclk;

  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang costs a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // only the bench timeout ends a stalled wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string what);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h0, x}, what);
  endtask

  task automatic tx(input logic [8:0] ch, input int nb);
    u_ssr_serial_master.send(ch, nb, link_pol);
    repeat (8) @(posedge mclk);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    chk({28'h0, irq, wake_req, vector_req, pready}, 32'h0, "reset outputs");
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], ra[i] == 8'h08 ? 8'h40 : 8'h00, "reset value");
    end
    apb(1'b0, 8'h1c, 8'h00);
    chk({31'h0, e}, 32'h1, "unmapped err");
    apb(1'b1, ssr_pkg::ADDR_RX_STATUS, 8'h07);
    rd(ssr_pkg::ADDR_RX_STATUS, 8'h00, "ro bits");
    apb(1'b1, ssr_pkg::ADDR_BAUD, 8'hff);
    rd(ssr_pkg::ADDR_BAUD, 8'h5b, "baud");
    apb(1'b1, ssr_pkg::ADDR_BAUD, 8'h00);
    $display("test reset done");
    apb(1'b1, ssr_pkg::ADDR_TX_STATUS, 8'h10);
    apb(1'b1, ssr_pkg::ADDR_IRQ_MASK, 8'h03);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ssr_pkg::ADDR_RX_STATUS, rows[i].rs);
      tx(rows[i].ch, rows[i].rs[6] ? 9 : 8);
      chk({31'h0, irq}, 32'h1, "irq");
      rd(ssr_pkg::ADDR_IRQ_STATUS, 8'h01, "event");
      rd(ssr_pkg::ADDR_RX_STATUS, rows[i].rs | {7'h0, rows[i].ch[8]}, "ninth");
      rd(ssr_pkg::ADDR_RX_DATA, rows[i].ch[7:0], "data");
      apb(1'b1, ssr_pkg::ADDR_IRQ_STATUS, 8'h01);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0, "irq clear");
    end
    rd(ssr_pkg::ADDR_BAUD, 8'h00, "never idle");
    $display("test rows done");
    apb(1'b1, ssr_pkg::ADDR_INT_CTRL, 8'h20);
    apb(1'b1, ssr_pkg::ADDR_RX_STATUS, 8'hd0);
    core_sleep <= 1'b1;
    tx(9'h0f0, 9);
    chk({30'h0, wake_req, vector_req}, 32'h2, "wake");
    apb(1'b1, ssr_pkg::ADDR_INT_CTRL, 8'he0);
    repeat (2) @(posedge mclk);
    chk({31'h0, vector_req}, 32'h1, "vector");
    core_sleep <= 1'b0;
    rd(ssr_pkg::ADDR_RX_DATA, 8'hf0, "sleep data");
    apb(1'b1, ssr_pkg::ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge mclk);
    chk({30'h0, wake_req, vector_req}, 32'h0, "wake off");
    $display("test sleep done");
    apb(1'b1, ssr_pkg::ADDR_RX_STATUS, 8'h90);
    tx(9'h011, 8);
    tx(9'h022, 8);
    tx(9'h033, 8);
    rd(ssr_pkg::ADDR_RX_STATUS, 8'h92, "overrun");
    rd(ssr_pkg::ADDR_IRQ_STATUS, 8'h03, "events");
    apb(1'b1, ssr_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "masked");
    rd(ssr_pkg::ADDR_RX_DATA, 8'h11, "first");
    rd(ssr_pkg::ADDR_RX_DATA, 8'h22, "second");
    apb(1'b1, ssr_pkg::ADDR_IRQ_STATUS, 8'h03);
    tx(9'h044, 8);
    rd(ssr_pkg::ADDR_IRQ_STATUS, 8'h00, "halted");
    apb(1'b1, ssr_pkg::ADDR_RX_STATUS, 8'h80);
    rd(ssr_pkg::ADDR_RX_STATUS, 8'h80, "cleared");
    tx(9'h055, 8);
    rd(ssr_pkg::ADDR_RX_DATA, 8'h55, "resumed");
    $display("test overrun done");
    apb(1'b1, ssr_pkg::ADDR_BAUD, 8'h10);
    link_pol = 1'b1;
    tx(9'h0a6, 8);
    rd(ssr_pkg::ADDR_RX_DATA, 8'ha6, "rising edge");
    tx(9'h0b7, 8);
    chk({31'h0, vector_req}, 32'h1, "pending");
    apb(1'b1, ssr_pkg::ADDR_RX_STATUS, 8'h00);
    repeat (3) @(posedge mclk);
    chk({31'h0, vector_req}, 32'h0, "port reset");
    $display("test polarity done");
    end_sim();
  end
endmodule // sync_slave_serial_receiver_test
